/* rtl/test_point_strap_capture.sv */
// debug test-point port: post-reset strap capture and output select
`timescale 1ns/10ps
module test_point_strap_capture (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] debug_test_points_in,
  output logic [7:0] debug_test_points_out,
  output logic [7:0] debug_test_points_oe,
  input wire logic [2:0] debug_select_straps_in,
  output logic [2:0] debug_select_straps_out,
  output logic [2:0] debug_select_straps_oe,
  input wire logic [2:0] debug_select_straps_value,
  output logic [7:0] init_config,
  output logic [2:0] captured_select,
  output logic capture_done,
  input wire logic [7:0] sw_sel_override,
  input wire logic [23:0] sw_sel_src,
  input wire logic [7:0] sw_out_value
);
  tp_strap_pkg::phase_e phase_q, phase_d;
  logic [8:0] cnt_q;
  logic [7:0] cfg_q;
  logic [2:0] sel_q;
  logic [23:0] src_q;
  tp_strap_pkg::pins_s tp_q, tp_d;
  logic [2:0] strap_oe_q;
  logic [2:0] strap_out_q;
  logic done_q;
  logic clk_60, clk_30, clk_15, clk_7p5;
  logic cnt_last;
  logic capture;
  logic [23:0] strap_src;
  logic [23:0] next_src;
  logic [7:0] src_level;
  logic [7:0] src_drive;

  tp_clk_div u_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .run(done_q),
    .clk_60(clk_60),
    .clk_30(clk_30),
    .clk_15(clk_15),
    .clk_7p5(clk_7p5)
  );

  assign cnt_last = (cnt_q == tp_strap_pkg::SAMPLE_LAST);
  assign capture = (phase_q == tp_strap_pkg::ST_CAPTURE);

  // upper strap bit is a don't-care; any other code falls back to float
  assign strap_src = (sel_q[1:0] == tp_strap_pkg::SEL_CLK_DEBUG[1:0]) ?
    {tp_strap_pkg::SRC_LOW, tp_strap_pkg::SRC_LOW, tp_strap_pkg::SRC_60,
     tp_strap_pkg::SRC_15, tp_strap_pkg::SRC_LOW, tp_strap_pkg::SRC_7P5,
     tp_strap_pkg::SRC_30, tp_strap_pkg::SRC_60} :
    {8{tp_strap_pkg::SRC_HIZ}};

  // software override per pin replaces the power-up default
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      assign next_src[3*g +: 3] = sw_sel_override[g] ?
        sw_sel_src[3*g +: 3] : strap_src[3*g +: 3];
      assign src_level[g] =
        (src_q[3*g +: 3] == tp_strap_pkg::SRC_60) ? clk_60 :
        (src_q[3*g +: 3] == tp_strap_pkg::SRC_30) ? clk_30 :
        (src_q[3*g +: 3] == tp_strap_pkg::SRC_15) ? clk_15 :
        (src_q[3*g +: 3] == tp_strap_pkg::SRC_7P5) ? clk_7p5 :
        (src_q[3*g +: 3] == tp_strap_pkg::SRC_SW) ? sw_out_value[g] :
        1'b0;
      assign src_drive[g] = (src_q[3*g +: 3] != tp_strap_pkg::SRC_HIZ);
    end
  endgenerate

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      tp_strap_pkg::ST_WAIT: begin
        if (cnt_last) begin
          phase_d = tp_strap_pkg::ST_CAPTURE;
        end
      end
      tp_strap_pkg::ST_CAPTURE: begin
        phase_d = tp_strap_pkg::ST_RUN;
      end
      tp_strap_pkg::ST_RUN: begin
        phase_d = tp_strap_pkg::ST_RUN;
      end
      default: begin
        phase_d = tp_strap_pkg::ST_WAIT;
      end
    endcase
  end

  always_comb begin
    tp_d.out = 8'h00;
    tp_d.oe = 8'h00;
    if (phase_q == tp_strap_pkg::ST_RUN) begin
      tp_d.out = src_level & src_drive;
      tp_d.oe = src_drive;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phase_q <= tp_strap_pkg::ST_WAIT;
      cnt_q <= 9'h000;
    end else begin
      phase_q <= phase_d;
      if (phase_q == tp_strap_pkg::ST_WAIT) begin
        cnt_q <= cnt_q + 9'h001;
      end
    end
  end

  // all eleven straps are taken on the same edge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cfg_q <= 8'h00;
      sel_q <= 3'h7;
    end else if (capture) begin
      cfg_q <= debug_test_points_in;
      sel_q <= debug_select_straps_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      src_q <= {8{tp_strap_pkg::SRC_HIZ}};
      done_q <= 1'b0;
    end else begin
      if (phase_q == tp_strap_pkg::ST_RUN) begin
        src_q <= next_src;
      end
      done_q <= (phase_q == tp_strap_pkg::ST_RUN);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tp_q <= '0;
      strap_oe_q <= 3'h0;
      strap_out_q <= 3'h0;
    end else begin
      tp_q <= tp_d;
      // straps turn to outputs once their level has been taken
      strap_oe_q <= {3{phase_q == tp_strap_pkg::ST_RUN}};
      strap_out_q <= debug_select_straps_value;
    end
  end

  assign debug_test_points_out = tp_q.out;
  assign debug_test_points_oe = tp_q.oe;
  assign debug_select_straps_out = strap_out_q;
  assign debug_select_straps_oe = strap_oe_q;
  assign init_config = cfg_q;
  assign captured_select = sel_q;
  assign capture_done = done_q;
endmodule

/* rtl/tp_strap_pkg.sv */
// constants and types for the debug test-point strap capture block
package tp_strap_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned SAMPLE_DELAY_NS = 1500;
  localparam int unsigned SAMPLE_CYCLES = (SAMPLE_DELAY_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W = 9;
  localparam logic [CNT_W-1:0] SAMPLE_LAST = CNT_W'(SAMPLE_CYCLES - 1);
  localparam int unsigned TP_W = 8;
  localparam int unsigned SEL_W = 3;
  localparam logic [2:0] SEL_CLK_DEBUG = 3'h2;
  localparam logic [1:0] SEL_LOW_MASK = 2'h3;
  localparam logic [7:0] DEFAULT_SEL_MASK = 8'hff;
  // per test-point source codes
  localparam logic [2:0] SRC_HIZ = 3'h0;
  localparam logic [2:0] SRC_LOW = 3'h1;
  localparam logic [2:0] SRC_60 = 3'h2;
  localparam logic [2:0] SRC_30 = 3'h3;
  localparam logic [2:0] SRC_15 = 3'h4;
  localparam logic [2:0] SRC_7P5 = 3'h5;
  localparam logic [2:0] SRC_SW = 3'h6;
  // divider: 200 MHz core, half-periods in core cycles are not integral
  // for 60/30 MHz, so a fractional accumulator approximates them
  localparam logic [15:0] ACC_STEP_120 = 16'h9999;
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b10
  } phase_e;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pins_s;
endpackage

/* rtl/tp_clk_div.sv */
// fractional clock generator for the debug clock outputs
`timescale 1ns/10ps
module tp_clk_div (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic run,
  output logic clk_60,
  output logic clk_30,
  output logic clk_15,
  output logic clk_7p5
);
  logic [15:0] acc_q;
  logic [16:0] acc_sum;
  logic [3:0] div_q;
  assign acc_sum = {1'b0, acc_q} + {1'b0, tp_strap_pkg::ACC_STEP_120};
  // carry rate ~120 MHz toggles gives ~60 MHz, jittered by one core cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_q <= 16'h0000;
      div_q <= 4'h0;
    end else if (run) begin
      acc_q <= acc_sum[15:0];
      if (acc_sum[16]) begin
        div_q <= div_q + 4'h1;
      end
    end else begin
      acc_q <= 16'h0000;
      div_q <= 4'h0;
    end
  end
  assign clk_60 = div_q[0];
  assign clk_30 = div_q[1];
  assign clk_15 = div_q[2];
  assign clk_7p5 = div_q[3];
endmodule

/* verif/test_point_strap_capture_monitor.sv */
// assertions on the test-point strap capture ports
`timescale 1ns/10ps
module test_point_strap_capture_monitor (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] debug_test_points_in,
  input wire logic [7:0] debug_test_points_out,
  input wire logic [7:0] debug_test_points_oe,
  input wire logic [2:0] debug_select_straps_in,
  input wire logic [2:0] debug_select_straps_out,
  input wire logic [2:0] debug_select_straps_oe,
  input wire logic [2:0] debug_select_straps_value,
  input wire logic [7:0] init_config,
  input wire logic [2:0] captured_select,
  input wire logic capture_done,
  input wire logic [7:0] sw_sel_override
);
  logic [9:0] cyc_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) cyc_q <= 10'h000;
    else if (cyc_q != 10'h3ff) cyc_q <= cyc_q + 10'h001;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  property p_rel; $rose(rstn) |-> debug_test_points_oe == 8'h00; endproperty
  a_rel: assert property (p_rel) else $error("drive at release");
  property p_pre; !capture_done |-> debug_test_points_oe == 8'h00
    && debug_select_straps_oe == 3'h0; endproperty
  a_pre: assert property (p_pre) else $error("drive before capture");
  // capture edge is 301, done rises at 302 and is first seen at 303
  property p_cnt; $rose(capture_done) |-> cyc_q == 10'h12e; endproperty
  a_cnt: assert property (p_cnt) else $error("capture delay");
  property p_cap; $rose(capture_done) |-> captured_select ==
    $past(debug_select_straps_in, 2) && init_config ==
    $past(debug_test_points_in, 2); endproperty
  a_cap: assert property (p_cap) else $error("capture value");
  property p_soe; capture_done |-> debug_select_straps_oe == 3'h7 &&
    debug_select_straps_out == $past(debug_select_straps_value); endproperty
  a_soe: assert property (p_soe) else $error("strap drive");
  property p_hold; capture_done |-> $stable(init_config) &&
    $stable(captured_select); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  // upper strap bit is a don't-care
  property p_dft; (capture_done && captured_select[1:0] != 2'h2 &&
    sw_sel_override == 8'h00) [*3] |-> debug_test_points_oe == 8'h00;
  endproperty
  a_dft: assert property (p_dft) else $error("default drive");
  property p_dbg; (capture_done && captured_select[1:0] == 2'h2 &&
    sw_sel_override == 8'h00) [*3] |-> debug_test_points_oe == 8'hff &&
    (debug_test_points_out & 8'hc8) == 8'h00; endproperty
  a_dbg: assert property (p_dbg) else $error("debug drive");
endmodule
bind test_point_strap_capture test_point_strap_capture_monitor u_mon (.*);

/* verif/board_straps.sv */
// board side: strap pull-ups, debug jumpers and test-point straps
`timescale 1ns/10ps
module board_straps (
  input wire logic [2:0] jumper,
  input wire logic [7:0] tp_strap,
  input wire logic [7:0] tp_oe,
  input wire logic [7:0] tp_out,
  input wire logic [2:0] sel_oe,
  input wire logic [2:0] sel_out,
  output logic [7:0] tp_pin,
  output logic [2:0] sel_pin
);
  // weak pull-up wins unless the jumper pulls the strap down
  assign sel_pin = (sel_oe & sel_out) | (~sel_oe & ~jumper);
  assign tp_pin = (tp_oe & tp_out) | (~tp_oe & tp_strap);
endmodule

/* verif/test_point_strap_capture_tb.sv */
// self-checking bench for the test-point strap capture block
`timescale 1ns/10ps
module test_point_strap_capture_tb;
  logic clk_sys = 0, rstn = 0, done;
  logic [2:0] jmp = 0, sval = 0, spin, so, soe, csel;
  logic [7:0] tps = 0, tpin, to, toe, cfg, ovr = 0, swv = 0;
  logic [23:0] src = 0;
  // 3'h6 checks that the upper strap bit is ignored
  logic [2:0] code [6] = '{3'h7, 3'h2, 3'h0, 3'h5, 3'h3, 3'h6};
  int error_cnt = 0, compares = 0, n, k;
  board_straps u_board_straps (.jumper(jmp), .tp_strap(tps), .tp_oe(toe),
    .tp_out(to), .sel_oe(soe), .sel_out(so), .tp_pin(tpin), .sel_pin(spin));
  test_point_strap_capture u_test_point_strap_capture (.clk_sys(clk_sys),
    .rstn(rstn), .debug_test_points_in(tpin), .debug_test_points_out(to),
    .debug_test_points_oe(toe), .debug_select_straps_in(spin),
    .debug_select_straps_out(so), .debug_select_straps_oe(soe),
    .debug_select_straps_value(sval), .init_config(cfg),
    .captured_select(csel), .capture_done(done), .sw_sel_override(ovr),
    .sw_sel_src(src), .sw_out_value(swv));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (e !== g) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic boot(logic [2:0] c);
    @(posedge clk_sys); #1;
    rstn = 0; jmp = ~c; tps = $urandom; ovr = 0; sval = $urandom;
    repeat (20) @(posedge clk_sys);
    #1 chk("oe_rst", 0, {toe, soe});
    rstn = 1;
    n = 0;
    while (done !== 1'b1 && n < 400) begin @(posedge clk_sys); #1; n++; end
    chk("t_cap", 302, n);
    repeat (2) @(posedge clk_sys);
    #1 chk("cfg", tps, cfg);
    chk("sel", {c, 3'h7}, {csel, soe});
    chk("tp_oe", c[1:0] == 2'h2 ? 8'hff : 8'h00, toe);
  endtask
  // tolerance of two edges covers the fractional divider jitter
  task automatic freq;
    int cnt [8];
    int e [8] = '{72, 36, 9, 0, 18, 72, 0, 0};
    logic [7:0] p;
    cnt = '{default:0}; p = to;
    repeat (120) begin
      @(posedge clk_sys); #1;
      for (k = 0; k < 8; k++) cnt[k] += int'(to[k] != p[k]);
      p = to;
    end
    for (k = 0; k < 8; k++) begin
      chk("edges", 1, cnt[k] + 3 > e[k] && cnt[k] < e[k] + 3);
    end
  endtask
  task automatic swt(logic dbg);
    logic [7:0] eo, ev;
    ovr = $urandom; swv = $urandom; eo = 0; ev = 0;
    for (k = 0; k < 8; k++) begin
      n = $urandom % 3;
      src[3*k+:3] = n == 0 ? 3'h0 : n == 1 ? 3'h1 : 3'h6;
      eo[k] = ovr[k] ? n != 0 : dbg;
      ev[k] = ovr[k] && n == 2 && swv[k];
    end
    repeat (3) @(posedge clk_sys);
    #1 chk("sw_oe", eo, toe);
    chk("sw_out", ev, to & ovr & eo);
  endtask
  initial forever #2.5 clk_sys = ~clk_sys;
  initial begin #50us; error_cnt++; end_sim; end
  initial begin
    void'($urandom(74787));
    for (int i = 0; i < 6; i++) begin
      boot(code[i]);
      if (code[i][1:0] == 2'h2) freq;
      swt(code[i][1:0] == 2'h2);
      $display("test %0d code %h done", i, code[i]);
    end
    end_sim;
  end
endmodule
